// [logic/rwm_pkg.sv]
package rwm_pkg;

	////////////////////////////////////////////////////////////////
	// register port map
	localparam logic [3:0] OFF_MAIN_WIN = 4'h0;
	localparam logic [3:0] OFF_SECOND_WIN = 4'h1;
	localparam logic [3:0] OFF_STATUS = 4'h2;
	localparam logic [3:0] OFF_FETCH_PAGE = 4'h3;

	// field positions
	localparam int BUS_HOLD_BIT = 7;
	localparam int CFG_RELOCATE_BIT = 2;
	localparam int CFG_SMALL_SPACE_BIT = 1;

	// values after reset, and the fixed small-space page
	localparam logic [7:0] MAIN_WIN_RST = 8'h00;
	localparam logic [6:0] SECOND_WIN_RST = 7'h00;
	localparam logic [7:0] PAGE_RST = 8'hff;
	localparam logic [15:0] PC_RST = 16'h2080;
	localparam logic [7:0] PAGE_SMALL = 8'hff;

	// lower register file window bases
	localparam logic [7:0] MAIN_LOW_32 = 8'he0;
	localparam logic [7:0] MAIN_LOW_64 = 8'hc0;
	localparam logic [7:0] MAIN_LOW_128 = 8'h80;
	localparam logic [7:0] SECOND_LOW_32 = 8'h60;
	localparam logic [7:0] SECOND_LOW_64 = 8'h40;
	localparam logic [7:0] MASK_32 = 8'h1f;
	localparam logic [7:0] MASK_64 = 8'h3f;
	localparam logic [7:0] MASK_128 = 8'h7f;
	localparam logic [7:0] SFR_PAGE_HI = 8'h1f;

	// non-windowable top peripheral block
	localparam logic [15:0] LOCKED_LO = 16'h1fe0;
	localparam logic [15:0] LOCKED_HI = 16'h1fff;

	// memory steering ranges
	localparam logic [7:0] ROM_PAGE = 8'hff;
	localparam logic [7:0] NEAR_PAGE = 8'h00;
	localparam logic [3:0] ROM_BLOCK = 4'h2;
	localparam logic [15:0] REGFILE_HI = 16'h03ff;
	localparam logic [15:0] SFR_LO = 16'h1f00;
	localparam logic [15:0] SFR_HI = 16'h1fff;

	// prefetch depth in bytes per variant
	localparam logic [3:0] QUEUE_BASE = 4'h4;
	localparam logic [3:0] QUEUE_ENH = 4'h8;

	////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		TGT_REGS = 3'b001,
		TGT_ROM = 3'b010,
		TGT_EXT = 3'b100
	} rwm_target_e;

	// direct/indirect register access from the core
	typedef struct packed {
		logic valid;
		logic direct;
		logic write;
		logic [15:0] addr;
	} rwm_dreq_s;

	// translated register access
	typedef struct packed {
		logic valid;
		logic ones;
		logic no_write;
		logic [15:0] addr;
	} rwm_dans_s;

	// 24-bit memory access from the core
	typedef struct packed {
		logic valid;
		logic extended;
		logic [23:0] addr;
	} rwm_mreq_s;

	// steered memory access
	typedef struct packed {
		logic valid;
		rwm_target_e target;
		logic [23:0] addr;
	} rwm_mans_s;

endpackage : rwm_pkg

// [logic/rwm_win_xlate.sv]
`timescale 1ns/100ps

// decodes one window select value and maps a direct address
module rwm_win_xlate (
	// window selection
	input wire logic [6:0] sel_i,
	input wire logic second_i,
	// direct address
	input wire logic [15:0] addr_i,
	output logic hit_o,
	output logic [15:0] mapped_o
);

	logic [15:0] base;
	logic [7:0] low;
	logic [7:0] mask;
	logic used;

	////////////////////////////////////////////////////////////////
	// size and segment from the select code; zero means no window
	always_comb
	begin
		base = 16'h0000;
		low = 8'h00;
		mask = 8'h00;
		used = 1'b0;
		if (sel_i[6])
		begin
			used = 1'b1;
			mask = rwm_pkg::MASK_32;
			low = second_i ? rwm_pkg::SECOND_LOW_32 : rwm_pkg::MAIN_LOW_32;
			base = sel_i[5] ? {rwm_pkg::SFR_PAGE_HI, sel_i[2:0], 5'h00}
				: {6'h00, sel_i[4:0], 5'h00};
		end
		else if (sel_i[5])
		begin
			used = 1'b1;
			mask = rwm_pkg::MASK_64;
			low = second_i ? rwm_pkg::SECOND_LOW_64 : rwm_pkg::MAIN_LOW_64;
			base = sel_i[4] ? {rwm_pkg::SFR_PAGE_HI, sel_i[1:0], 6'h00}
				: {6'h00, sel_i[3:0], 6'h00};
		end
		else if (sel_i[4] && !second_i)
		begin
			used = 1'b1;
			mask = rwm_pkg::MASK_128;
			low = rwm_pkg::MAIN_LOW_128;
			base = sel_i[3] ? {rwm_pkg::SFR_PAGE_HI, sel_i[0], 7'h00}
				: {6'h00, sel_i[2:0], 7'h00};
		end
		// offset kept, segment base swapped
		hit_o = used && (addr_i[15:8] == 8'h00) && ((addr_i[7:0] & ~mask) == low);
		mapped_o = base | {8'h00, addr_i[7:0] & mask};
	end

endmodule : rwm_win_xlate

// [logic/rwm_addr_map.sv]
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps

module rwm_addr_map #(
	parameter bit ENHANCED = 1'b0,
	parameter bit ROM_FITTED = 1'b1
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [7:0] reg_rdata_o,
	// configuration and pins
	input wire logic [7:0] config_byte_one_i,
	input wire logic external_access_pin_i,
	output logic bus_hold_enable_o,
	// register file access
	input rwm_pkg::rwm_dreq_s dreq_i,
	output rwm_pkg::rwm_dans_s dans_o,
	// memory access
	input rwm_pkg::rwm_mreq_s mreq_i,
	output rwm_pkg::rwm_mans_s mans_o,
	// instruction fetch
	input wire logic fetch_jump_i,
	input wire logic [23:0] fetch_target_i,
	input wire logic fetch_step_i,
	input wire logic [3:0] fetch_bytes_i,
	output logic [23:0] fetch_addr_o,
	output rwm_pkg::rwm_target_e fetch_target_o,
	output logic [3:0] upper_address_lines_o,
	output logic [3:0] queue_depth_o,
	// bus arbitration
	input wire logic fetch_req_i,
	input wire logic data_req_i,
	output logic grant_fetch_o,
	output logic grant_data_o
);

	////////////////////////////////////////////////////////////////
	// all state of the block
	typedef struct packed {
		logic [7:0] main_win;
		logic [6:0] second_win;
		logic cfg_taken;
		logic rom_relocate_select;
		logic small_space_select;
		logic pin_meta;
		logic pin_sync;
		logic [7:0] page_program_counter;
		logic [15:0] master_program_counter;
		logic [7:0] rdata;
		rwm_pkg::rwm_dans_s dans;
		rwm_pkg::rwm_mans_s mans;
		rwm_pkg::rwm_target_e fetch_tgt;
		logic [3:0] upper;
		logic [3:0] qdepth;
		logic grant_fetch;
		logic grant_data;
	} rwm_state_s;

	rwm_state_s state_reg;
	rwm_state_s state_next;

	logic main_hit;
	logic second_hit;
	logic [15:0] main_mapped;
	logic [15:0] second_mapped;
	logic [23:0] fetch_addr;
	logic main_take;
	logic second_take;
	rwm_pkg::rwm_mans_s fetch_steer;

	////////////////////////////////////////////////////////////////
	// inclusive range test on a 16-bit address
	function automatic logic in_span(
		input logic [15:0] addr,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		return (addr >= lo) && (addr <= hi);
	endfunction : in_span

	////////////////////////////////////////////////////////////////
	// steering of one 24-bit access to registers, ROM or external bus
	// the pin is looked at only inside the ROM block; elsewhere it cannot matter
	function automatic rwm_pkg::rwm_mans_s steer(
		input logic valid,
		input logic extended,
		input logic [23:0] addr,
		input logic relocate,
		input logic pin
	);
		rwm_pkg::rwm_mans_s ans;
		logic [7:0] page;
		logic in_block;
		ans.valid = valid;
		ans.target = rwm_pkg::TGT_EXT;
		page = extended ? addr[23:16] : rwm_pkg::NEAR_PAGE;
		in_block = (addr[15:12] == rwm_pkg::ROM_BLOCK);
		// external side sees only the low four page bits
		ans.addr = {4'h0, page[3:0], addr[15:0]};
		if (page == rwm_pkg::NEAR_PAGE && (addr[15:0] <= rwm_pkg::REGFILE_HI
			|| in_span(addr[15:0], rwm_pkg::SFR_LO, rwm_pkg::SFR_HI)))
		begin
			ans.target = rwm_pkg::TGT_REGS;
			ans.addr = {rwm_pkg::NEAR_PAGE, addr[15:0]};
		end
		else if (ROM_FITTED && in_block && page == rwm_pkg::ROM_PAGE)
		begin
			// pin alone decides the upper ROM range
			if (pin)
			begin
				ans.target = rwm_pkg::TGT_ROM;
				ans.addr = {rwm_pkg::ROM_PAGE, addr[15:0]};
			end
		end
		else if (ROM_FITTED && in_block && page == rwm_pkg::NEAR_PAGE)
		begin
			// page-zero copy only when relocated and pin high
			if (relocate && pin)
			begin
				ans.target = rwm_pkg::TGT_ROM;
				ans.addr = {rwm_pkg::ROM_PAGE, addr[15:0]};
			end
		end
		return ans;
	endfunction : steer

	////////////////////////////////////////////////////////////////
	// one decoder per window; main window ignores the bus hold bit
	// the second decoder runs on both variants; its hit is masked on the base one
	rwm_win_xlate u_main_win (
		.sel_i(state_reg.main_win[6:0]),
		.second_i(1'b0),
		.addr_i(dreq_i.addr),
		.hit_o(main_hit),
		.mapped_o(main_mapped)
	);

	rwm_win_xlate u_second_win (
		.sel_i(state_reg.second_win),
		.second_i(1'b1),
		.addr_i(dreq_i.addr),
		.hit_o(second_hit),
		.mapped_o(second_mapped)
	);

	// fetch address as page over program counter
	assign fetch_addr = {state_reg.page_program_counter, state_reg.master_program_counter};

	// window hits count only for direct-mode accesses
	assign main_take = dreq_i.direct && main_hit;
	assign second_take = dreq_i.direct && second_hit && ENHANCED;

	// fetch steering always treats the fetch address as extended
	assign fetch_steer = steer(1'b1, 1'b1, fetch_addr, state_reg.rom_relocate_select,
		state_reg.pin_sync);

	////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		state_next = state_reg;

		// pin passes two flip-flops before use
		// status shows the synchronised pin, the same value that steering uses
		state_next.pin_meta = external_access_pin_i;
		state_next.pin_sync = state_reg.pin_meta;

		// configuration caught once on the first edge after reset
		// cfg_taken only clears in reset, so later config changes are ignored
		if (!state_reg.cfg_taken)
		begin
			state_next.cfg_taken = 1'b1;
			state_next.rom_relocate_select = config_byte_one_i[rwm_pkg::CFG_RELOCATE_BIT];
			state_next.small_space_select =
				config_byte_one_i[rwm_pkg::CFG_SMALL_SPACE_BIT];
		end

		// register writes; visible to the next access
		if (reg_write_i)
		begin
			unique case (reg_addr_i)
				rwm_pkg::OFF_MAIN_WIN: state_next.main_win = reg_wdata_i;
				rwm_pkg::OFF_SECOND_WIN:
				begin
					if (ENHANCED)
					begin
						state_next.second_win = reg_wdata_i[6:0];
					end
				end
				default:
				begin
				end
			endcase
		end

		// register reads, answered one cycle later
		// read data fall back to zero outside their slot
		state_next.rdata = 8'h00;
		if (reg_read_i)
		begin
			unique case (reg_addr_i)
				rwm_pkg::OFF_MAIN_WIN: state_next.rdata = state_reg.main_win;
				rwm_pkg::OFF_SECOND_WIN: state_next.rdata = {1'b0, state_reg.second_win};
				rwm_pkg::OFF_STATUS: state_next.rdata = {4'h0, state_reg.pin_sync,
					state_reg.rom_relocate_select, state_reg.small_space_select,
					state_reg.cfg_taken};
				rwm_pkg::OFF_FETCH_PAGE: state_next.rdata = state_reg.page_program_counter;
				default: state_next.rdata = 8'h00;
			endcase
		end

		// direct accesses that hit a window are mapped; all others stay literal
		state_next.dans.valid = dreq_i.valid;
		state_next.dans.ones = 1'b0;
		state_next.dans.no_write = 1'b0;
		state_next.dans.addr = dreq_i.addr;
		if (main_take)
		begin
			state_next.dans.addr = main_mapped;
		end
		else if (second_take)
		begin
			state_next.dans.addr = second_mapped;
		end
		// locked top block on base variant only; below it stays normal
		// the enhanced variant has no registers there, so it windows them freely
		if (!ENHANCED && main_take
			&& in_span(main_mapped, rwm_pkg::LOCKED_LO, rwm_pkg::LOCKED_HI))
		begin
			state_next.dans.ones = !dreq_i.write;
			state_next.dans.no_write = dreq_i.write;
		end

		// data and fetch steering
		state_next.mans = steer(mreq_i.valid, mreq_i.extended, mreq_i.addr,
			state_reg.rom_relocate_select, state_reg.pin_sync);

		// program counter and page counter
		// jump wins over step; small mode overrides any loaded page
		if (fetch_jump_i)
		begin
			state_next.master_program_counter = fetch_target_i[15:0];
			state_next.page_program_counter = fetch_target_i[23:16];
		end
		else if (fetch_step_i)
		begin
			state_next.master_program_counter =
				state_reg.master_program_counter + {12'h000, fetch_bytes_i};
		end
		if (state_reg.small_space_select)
		begin
			state_next.page_program_counter = rwm_pkg::PAGE_SMALL;
		end
		state_next.fetch_tgt = fetch_steer.target;
		state_next.upper = state_next.page_program_counter[3:0];

		// prefetch depth and arbitration by variant
		// the losing side of a tie gets no grant and must keep requesting
		state_next.qdepth = ENHANCED ? rwm_pkg::QUEUE_ENH : rwm_pkg::QUEUE_BASE;
		if (ENHANCED)
		begin
			state_next.grant_data = data_req_i;
			state_next.grant_fetch = fetch_req_i && !data_req_i;
		end
		else
		begin
			state_next.grant_fetch = fetch_req_i;
			state_next.grant_data = data_req_i && !fetch_req_i;
		end
	end

	////////////////////////////////////////////////////////////////
	// state register
	// reset leaves both windows closed and the fetch address at page ff
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg.main_win <= rwm_pkg::MAIN_WIN_RST;
			state_reg.second_win <= rwm_pkg::SECOND_WIN_RST;
			state_reg.cfg_taken <= 1'b0;
			state_reg.rom_relocate_select <= 1'b0;
			state_reg.small_space_select <= 1'b0;
			state_reg.pin_meta <= 1'b0;
			state_reg.pin_sync <= 1'b0;
			state_reg.page_program_counter <= rwm_pkg::PAGE_RST;
			state_reg.master_program_counter <= rwm_pkg::PC_RST;
			state_reg.rdata <= 8'h00;
			state_reg.dans <= '0;
			state_reg.mans <= '{valid: 1'b0, target: rwm_pkg::TGT_EXT, addr: 24'h000000};
			state_reg.fetch_tgt <= rwm_pkg::TGT_EXT;
			state_reg.upper <= 4'hf;
			state_reg.qdepth <= 4'h0;
			state_reg.grant_fetch <= 1'b0;
			state_reg.grant_data <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs straight from state
	// the fetch address is a plain concatenation of two registers
	assign reg_rdata_o = state_reg.rdata;
	assign bus_hold_enable_o = state_reg.main_win[rwm_pkg::BUS_HOLD_BIT];
	assign dans_o = state_reg.dans;
	assign mans_o = state_reg.mans;
	assign fetch_addr_o = fetch_addr;
	assign fetch_target_o = state_reg.fetch_tgt;
	assign upper_address_lines_o = state_reg.upper;
	assign queue_depth_o = state_reg.qdepth;
	assign grant_fetch_o = state_reg.grant_fetch;
	assign grant_data_o = state_reg.grant_data;

endmodule : rwm_addr_map

// [sim/rwm_addr_map_props.sv]
`timescale 1ns/100ps

// port-level checks on the mapper
module rwm_addr_map_chk #(
	parameter bit ENHANCED = 1'b0
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic bus_hold_enable_o,
	// accesses
	input rwm_pkg::rwm_dreq_s dreq_i,
	input rwm_pkg::rwm_dans_s dans_o,
	input rwm_pkg::rwm_mreq_s mreq_i,
	input rwm_pkg::rwm_mans_s mans_o,
	// fetch and arbitration
	input wire logic fetch_jump_i,
	input wire logic fetch_step_i,
	input wire logic [3:0] fetch_bytes_i,
	input wire logic [23:0] fetch_addr_o,
	input wire logic [3:0] upper_address_lines_o,
	input wire logic [3:0] queue_depth_o,
	input wire logic fetch_req_i,
	input wire logic data_req_i,
	input wire logic grant_fetch_o,
	input wire logic grant_data_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////
	// main window loaded, then a direct access right behind it
	sequence s_win_direct(v, a);
		reg_write_i && reg_addr_i == rwm_pkg::OFF_MAIN_WIN && reg_wdata_i[6:0] == v
			##1 dreq_i.valid && dreq_i.direct && dreq_i.addr == a;
	endsequence
	property p_win_upper;
		s_win_direct(7'h17, 16'h0080) |=> dans_o.valid && dans_o.addr == 16'h0380;
	endproperty
	property p_locked_ones;
		s_win_direct(7'h1f, 16'h00e7) ##0 (!dreq_i.write && !ENHANCED)
			|=> dans_o.ones && dans_o.addr == 16'h1fe7;
	endproperty
	property p_read_idle;
		!reg_read_i |=> reg_rdata_o == 8'h00;
	endproperty
	property p_bus_hold;
		reg_write_i && reg_addr_i == rwm_pkg::OFF_MAIN_WIN
			|=> bus_hold_enable_o == $past(reg_wdata_i[7]);
	endproperty
	property p_indirect;
		dreq_i.valid && !dreq_i.direct |=> dans_o.valid && dans_o.addr == $past(dreq_i.addr);
	endproperty
	property p_page_lines;
		upper_address_lines_o == fetch_addr_o[19:16];
	endproperty
	property p_depth;
		!$past(rst_i) |-> queue_depth_o == (ENHANCED ? rwm_pkg::QUEUE_ENH : rwm_pkg::QUEUE_BASE);
	endproperty
	property p_grant;
		fetch_req_i && data_req_i
			|=> (ENHANCED ? grant_data_o && !grant_fetch_o : grant_fetch_o && !grant_data_o);
	endproperty
	property p_far_page;
		mreq_i.valid && mreq_i.extended && mreq_i.addr[23:16] == 8'h01
			|=> mans_o.target == rwm_pkg::TGT_EXT && mans_o.addr == {4'h0, $past(mreq_i.addr[19:0])};
	endproperty
	property p_step;
		fetch_step_i && !fetch_jump_i
			|=> fetch_addr_o[15:0] == $past(fetch_addr_o[15:0]) + {12'h000, $past(fetch_bytes_i)};
	endproperty

	////////////////////////////////////////////////////////////////
	a_win_upper: assert property (p_win_upper)
		else $error("window 17 not applied to next direct access");
	a_locked_ones: assert property (p_locked_ones)
		else $error("locked block read through window not all ones");
	a_read_idle: assert property (p_read_idle)
		else $error("read data outside its slot");
	a_bus_hold: assert property (p_bus_hold)
		else $error("bus hold enable not from top window bit");
	a_indirect: assert property (p_indirect)
		else $error("indirect access address altered");
	a_page_lines: assert property (p_page_lines)
		else $error("upper address lines not low page bits");
	a_depth: assert property (p_depth)
		else $error("queue depth wrong");
	a_grant: assert property (p_grant)
		else $error("arbitration favours wrong side");
	a_far_page: assert property (p_far_page)
		else $error("far page access not external");
	a_step: assert property (p_step)
		else $error("program counter step wrong");
endmodule : rwm_addr_map_chk

bind rwm_addr_map rwm_addr_map_chk #(.ENHANCED(ENHANCED)) rwm_addr_map_chk_i (
	.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
	.bus_hold_enable_o, .dreq_i, .dans_o, .mreq_i, .mans_o, .fetch_jump_i, .fetch_step_i,
	.fetch_bytes_i, .fetch_addr_o, .upper_address_lines_o, .queue_depth_o, .fetch_req_i,
	.data_req_i, .grant_fetch_o, .grant_data_o);

// [sim/rwm_core_model.sv]
`timescale 1ns/100ps

// core address generator: one-cycle requests toward the mapper
module rwm_core_model (
	// clock
	input wire logic mclk_i,
	// requests
	output rwm_pkg::rwm_dreq_s dreq_o,
	output rwm_pkg::rwm_mreq_s mreq_o
);
	// idle at time zero
	initial
	begin
		dreq_o = '0;
		mreq_o = '0;
	end

	// register file access; idle address lines show the inverse pattern
	task automatic dacc(input logic dir, input logic wr, input logic [15:0] a);
		dreq_o <= '{1'b1, dir, wr, a};
		@(posedge mclk_i);
		dreq_o <= '{1'b0, 1'b0, 1'b0, ~a};
		@(posedge mclk_i);
	endtask : dacc

	// memory access
	task automatic macc(input logic x, input logic [23:0] a);
		mreq_o <= '{1'b1, x, a};
		@(posedge mclk_i);
		mreq_o <= '{1'b0, 1'b0, ~a};
		@(posedge mclk_i);
	endtask : macc
endmodule : rwm_core_model

// [sim/rwm_addr_map_tb_top.sv]
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module rwm_addr_map_tb_top;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] reg_addr_i = 4'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_write_i = 1'b0;
	logic reg_read_i = 1'b0;
	logic [7:0] reg_rdata_o;
	logic [7:0] config_byte_one_i = 8'h00;
	logic external_access_pin_i = 1'b1;
	logic bus_hold_enable_o;
	rwm_pkg::rwm_dreq_s dreq_i;
	rwm_pkg::rwm_dans_s dans_o;
	rwm_pkg::rwm_mreq_s mreq_i;
	rwm_pkg::rwm_mans_s mans_o;
	logic fetch_jump_i = 1'b0;
	logic [23:0] fetch_target_i = 24'h000000;
	logic fetch_step_i = 1'b0;
	logic [3:0] fetch_bytes_i = 4'h0;
	logic [23:0] fetch_addr_o;
	rwm_pkg::rwm_target_e fetch_target_o;
	logic [3:0] upper_address_lines_o;
	logic [3:0] queue_depth_o;
	logic fetch_req_i = 1'b0;
	logic data_req_i = 1'b0;
	logic grant_fetch_o;
	logic grant_data_o;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;
	int seed = 32'h368747ee;
	logic rd_flag = 1'b0;
	logic [15:0] tmp;
	logic [7:0] er;
	rwm_pkg::rwm_dans_s ed;
	rwm_pkg::rwm_mans_s em;
	logic [7:0] exp_rd[$];
	rwm_pkg::rwm_dans_s exp_dans[$];
	rwm_pkg::rwm_mans_s exp_mans[$];

	rwm_addr_map #(.ENHANCED(1'b0), .ROM_FITTED(1'b1)) rwm_addr_map_i (.mclk_i, .rst_i,
		.reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
		.config_byte_one_i, .external_access_pin_i, .bus_hold_enable_o, .dreq_i, .dans_o,
		.mreq_i, .mans_o, .fetch_jump_i, .fetch_target_i, .fetch_step_i, .fetch_bytes_i,
		.fetch_addr_o, .fetch_target_o, .upper_address_lines_o, .queue_depth_o,
		.fetch_req_i, .data_req_i, .grant_fetch_o, .grant_data_o);
	rwm_core_model rwm_core_model_i (.mclk_i, .dreq_o(dreq_i), .mreq_o(mreq_i));

	////////////////////////////////////////////////////////////////
	// clock and hang guard
	always #4 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			close_out();
		end
	end

	// result watcher: each result is paired with the oldest note
	always @(posedge mclk_i)
		rd_flag <= reg_read_i;
	always @(negedge mclk_i)
	begin
		if (rd_flag)
		begin
			er = exp_rd.pop_front();
			`CHK("rdata", er, reg_rdata_o)
		end
		if (dans_o.valid)
		begin
			ed = exp_dans.pop_front();
			`CHK("dans", ed, dans_o)
		end
		if (mans_o.valid)
		begin
			em = exp_mans.pop_front();
			`CHK("mans", em, mans_o)
		end
	end

	////////////////////////////////////////////////////////////////
	// register port and access tasks
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge mclk_i);
		reg_write_i <= 1'b0;
		@(posedge mclk_i);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_rd.push_back(e);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		@(posedge mclk_i);
		reg_read_i <= 1'b0;
		@(posedge mclk_i);
	endtask : rd
	task automatic da(input logic dir, input logic w, input logic [15:0] a,
		input logic [15:0] m, input logic o);
		exp_dans.push_back(rwm_pkg::rwm_dans_s'{1'b1, o & ~w, o & w, m});
		rwm_core_model_i.dacc(dir, w, a);
	endtask : da
	// main window write with a direct access in the very next cycle
	task automatic wd(input logic [7:0] v, input logic [15:0] a, input logic [15:0] m,
		input logic o);
		fork
			wr(rwm_pkg::OFF_MAIN_WIN, v);
			begin
				@(posedge mclk_i);
				da(1'b1, 1'b0, a, m, o);
			end
		join
	endtask : wd
	task automatic ma(input logic x, input logic [23:0] a, input rwm_pkg::rwm_target_e t,
		input logic [23:0] m);
		exp_mans.push_back(rwm_pkg::rwm_mans_s'{1'b1, t, m});
		rwm_core_model_i.macc(x, a);
	endtask : ma
	task automatic fj(input logic j, input logic [23:0] t, input logic [3:0] n,
		input logic [23:0] e, input rwm_pkg::rwm_target_e g);
		fetch_jump_i <= j;
		fetch_step_i <= ~j;
		fetch_target_i <= t;
		fetch_bytes_i <= n;
		@(posedge mclk_i);
		fetch_jump_i <= 1'b0;
		fetch_step_i <= 1'b0;
		@(negedge mclk_i);
		`CHK("fetch", e, fetch_addr_o)
		`CHK("upper", e[19:16], upper_address_lines_o)
		@(negedge mclk_i);
		`CHK("fetch target", g, fetch_target_o)
		@(posedge mclk_i);
	endtask : fj
	task automatic rst_with(input logic [7:0] c);
		rst_i <= 1'b1;
		config_byte_one_i <= c;
		repeat (5) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
	endtask : rst_with
	task automatic pin(input logic p);
		external_access_pin_i <= p;
		repeat (3) @(posedge mclk_i);
	endtask : pin
	task automatic close_out();
		if (exp_rd.size() + exp_dans.size() + exp_mans.size() != 0)
		begin
			failures++;
			$display("MISMATCH pending exp 0 got %0d",
				exp_rd.size() + exp_dans.size() + exp_mans.size());
		end
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		rst_with(8'h00);
		`CHK("depth", rwm_pkg::QUEUE_BASE, queue_depth_o)
		rd(rwm_pkg::OFF_STATUS, 8'h09);
		config_byte_one_i <= 8'h06;
		wd(8'h17, 16'h0080, 16'h0380, 1'b0);
		da(1'b1, 1'b0, 16'h0020, 16'h0020, 1'b0);
		da(1'b0, 1'b0, 16'h0080, 16'h0080, 1'b0);
		repeat (4)
		begin
			tmp = 16'($random(seed)) & 16'h03ff;
			da(1'b0, 1'b1, tmp, tmp, 1'b0);
		end
		wr(rwm_pkg::OFF_MAIN_WIN, 8'h4a);
		da(1'b1, 1'b0, 16'h00eb, 16'h014b, 1'b0);
		wd(8'h1f, 16'h00e7, 16'h1fe7, 1'b1);
		da(1'b1, 1'b1, 16'h00e7, 16'h1fe7, 1'b1);
		da(1'b1, 1'b0, 16'h0082, 16'h1f82, 1'b0);
		da(1'b1, 1'b0, 16'h00df, 16'h1fdf, 1'b0);
		wd(8'h97, 16'h0080, 16'h0380, 1'b0);
		`CHK("hold", 1'b1, bus_hold_enable_o)
		rd(rwm_pkg::OFF_MAIN_WIN, 8'h97);
		wd(8'h2e, 16'h00c5, 16'h0385, 1'b0);
		da(1'b1, 1'b0, 16'h00bf, 16'h00bf, 1'b0);
		wd(8'h00, 16'h0080, 16'h0080, 1'b0);
		wr(rwm_pkg::OFF_SECOND_WIN, 8'h4a);
		rd(rwm_pkg::OFF_SECOND_WIN, 8'h00);
		wr(4'h9, 8'h55);
		rd(4'h9, 8'h00);
		$display("test windows done");
		ma(1'b1, 24'hff2345, rwm_pkg::TGT_ROM, 24'hff2345);
		ma(1'b1, 24'h012345, rwm_pkg::TGT_EXT, 24'h012345);
		ma(1'b0, 24'h002345, rwm_pkg::TGT_EXT, 24'h002345);
		ma(1'b0, 24'h000100, rwm_pkg::TGT_REGS, 24'h000100);
		pin(1'b0);
		ma(1'b1, 24'hff2345, rwm_pkg::TGT_EXT, 24'h0f2345);
		ma(1'b1, 24'h012345, rwm_pkg::TGT_EXT, 24'h012345);
		fj(1'b1, 24'h012000, 4'h0, 24'h012000, rwm_pkg::TGT_EXT);
		fj(1'b0, 24'h000000, 4'h6, 24'h012006, rwm_pkg::TGT_EXT);
		fj(1'b1, 24'hff2080, 4'h0, 24'hff2080, rwm_pkg::TGT_EXT);
		fetch_req_i <= 1'b1;
		data_req_i <= 1'b1;
		@(posedge mclk_i);
		fetch_req_i <= 1'b0;
		data_req_i <= 1'b0;
		@(negedge mclk_i);
		`CHK("grant", 2'b10, {grant_fetch_o, grant_data_o})
		@(posedge mclk_i);
		rd(rwm_pkg::OFF_STATUS, 8'h01);
		$display("test steering and fetch done");
		pin(1'b1);
		rst_with(8'h06);
		rd(rwm_pkg::OFF_STATUS, 8'h0f);
		ma(1'b0, 24'h002345, rwm_pkg::TGT_ROM, 24'hff2345);
		ma(1'b1, 24'hff2345, rwm_pkg::TGT_ROM, 24'hff2345);
		fj(1'b1, 24'h012000, 4'h0, 24'hff2000, rwm_pkg::TGT_ROM);
		pin(1'b0);
		ma(1'b0, 24'h002345, rwm_pkg::TGT_EXT, 24'h002345);
		ma(1'b1, 24'hff2345, rwm_pkg::TGT_EXT, 24'h0f2345);
		fj(1'b1, 24'h012000, 4'h0, 24'hff2000, rwm_pkg::TGT_EXT);
		$display("test relocation and small space done");
		repeat (2) @(posedge mclk_i);
		close_out();
	end
endmodule : rwm_addr_map_tb_top
